//--- design/xmb_ext_bus.sv
// external memory bus engine with port pin muxing and reset pin handling
`include "xmb_defs.svh"

module xmb_ext_bus
   import xmb_pkg::*;
(
   // clock and power-on reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // reset and strap pins
   input wire logic rstPin,
   input wire logic external_access_select,
   // configuration and port latches from software
   input wire logic [7:0] first_configuration_byte,
   input wire logic [7:0] p0Latch,
   input wire logic [7:0] p1Latch,
   input wire logic [7:0] p2Latch,
   input wire logic [7:0] p3Latch,
   // power mode requests from the core
   input wire logic idleReq,
   input wire logic powerDownReq,
   input wire logic wakeIrq,
   // core access request
   input wire logic reqValid,
   input wire logic reqWrite,
   input wire logic reqCode,
   input wire logic [17:0] reqAddr,
   input wire logic [7:0] reqWdata,
   // core access answer
   output logic reqReady,
   output logic rspValid,
   output logic rspInternal,
   output logic [7:0] rspData,
   // core status
   output logic coreReset,
   output logic extAccessLatched,
   output logic idleMode,
   output logic powerDownMode,
   // port 0, muxed low address and data
   input wire logic [7:0] muxed_low_addr_data_in,
   output logic [7:0] muxed_low_addr_data_out,
   output logic [7:0] muxed_low_addr_data_oe,
   // ports 1 to 3 and strobes
   output logic [7:0] p1Out,
   output logic [7:0] upper_address_lines,
   output logic [7:0] p3Out,
   output logic addrLatchStrobe,
   output logic program_store_strobe_n
);

   xmb_bus_t s_r;
   xmb_bus_t s_nxt;
   logic pinRst_n;
   logic [1:0] sizeSel;
   logic [1:0] readMap;
   logic rdOnPin;
   logic onChip;

   // =====================================================================
   // helpers

   // address inside the program-strobe window chosen by the read map
   function automatic logic inPsenRange(input logic [1:0] map, input logic [17:0] addr);
      logic upper;
      upper = (addr >= `XMB_UPPER_64K_BASE);
      unique case (map)
         `XMB_RDMAP_ALL: inPsenRange = 1'b1;
         `XMB_RDMAP_UPPER: inPsenRange = upper;
         `XMB_RDMAP_LOWER: inPsenRange = !upper;
         `XMB_RDMAP_CODE: inPsenRange = 1'b0;
      endcase
   endfunction

   // pin levels between bus cycles, shared by the idle and closing phases
   function automatic xmb_bus_t idlePins(input xmb_bus_t s, input logic [7:0] p0l,
      input logic [7:0] p2l);
      idlePins = s;
      idlePins.ale = 1'b0;
      idlePins.p0Out = `XMB_BYTE_ZERO;
      // open-drain port 0: only latch zeros pull low, ones float
      idlePins.p0Oe = ~p0l;
      idlePins.p2Out = p2l;
   endfunction

   // =====================================================================
   // reset pin qualifier and strap latch
   xmb_rst_qual u_rst_qual (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .rstPin(rstPin),
      .extAccessPin(external_access_select),
      .coreReset(coreReset),
      .extAccessLatched(extAccessLatched)
   );

   // pins drop to reset state without waiting for a clock edge
   assign pinRst_n = rst_n & ~rstPin;

   // =====================================================================
   // configuration decode
   assign sizeSel = first_configuration_byte[`XMB_CFG_SIZE_MSB:`XMB_CFG_SIZE_LSB];
   assign readMap = {first_configuration_byte[`XMB_CFG_RDMAP_HI],
                     first_configuration_byte[`XMB_CFG_RDMAP_LO]};
   // read strobe only exists when bit 16 is not taken by the address
   assign rdOnPin = (sizeSel == `XMB_SIZE_64K) && (readMap == `XMB_RDMAP_CODE);
   // on-chip fetch only with the strap latched high and below the code top
   assign onChip = extAccessLatched && (reqAddr < `XMB_ONCHIP_CODE_TOP);

   // =====================================================================
   // bus cycle sequencing
   always_comb
   begin
      s_nxt = s_r;
      s_nxt.rspValid = 1'b0;
      s_nxt.rspInternal = 1'b0;
      unique case (s_r.st)
         ST_IDLE:
         begin
            s_nxt = idlePins(s_nxt, p0Latch, p2Latch);
            if (reqValid && s_r.reqReady)
            begin
               if (reqCode && onChip)
               begin
                  // internal code memory answers; no pin activity
                  s_nxt.rspValid = 1'b1;
                  s_nxt.rspInternal = 1'b1;
               end
               else
               begin
                  s_nxt.addr = reqAddr;
                  s_nxt.wdata = reqWdata;
                  s_nxt.write = reqWrite;
                  s_nxt.code = reqCode;
                  s_nxt.useRd = !reqCode && !reqWrite && rdOnPin &&
                                !inPsenRange(readMap, reqAddr);
                  s_nxt.ale = 1'b1;
                  s_nxt.p0Out = reqAddr[`XMB_ADDR_LO_MSB:`XMB_ADDR_LO_LSB];
                  s_nxt.p0Oe = `XMB_BYTE_ONES;
                  s_nxt.p2Out = reqAddr[`XMB_ADDR_HI_MSB:`XMB_ADDR_HI_LSB];
                  s_nxt.st = ST_ALE;
               end
            end
         end
         ST_ALE:
         begin
            // address stays put past the falling latch edge for hold time
            s_nxt.ale = 1'b0;
            s_nxt.st = ST_AHOLD;
         end
         ST_AHOLD:
         begin
            s_nxt.cnt = `XMB_STROBE_CYCLES - `XMB_CNT_ONE;
            s_nxt.st = ST_STROBE;
            if (s_r.write)
            begin
               s_nxt.p0Out = s_r.wdata;
               s_nxt.wrAct = 1'b1;
            end
            else
            begin
               // release the lines so memory can drive the data byte
               s_nxt.p0Oe = `XMB_BYTE_ZERO;
               s_nxt.rdAct = s_r.useRd;
               s_nxt.psenAct = !s_r.useRd &&
                               (s_r.code || inPsenRange(readMap, s_r.addr) || !rdOnPin);
            end
         end
         ST_STROBE:
         begin
            // data byte taken as the strobe rises, after the full pulse width
            if (s_r.cnt == `XMB_CNT_ZERO)
            begin
               s_nxt.rspData = muxed_low_addr_data_in;
               s_nxt.psenAct = 1'b0;
               s_nxt.rdAct = 1'b0;
               s_nxt.wrAct = 1'b0;
               s_nxt.st = ST_END;
            end
            else
            begin
               s_nxt.cnt = s_r.cnt - `XMB_CNT_ONE;
            end
         end
         ST_END:
         begin
            // write data held one cycle past the strobe edge
            s_nxt.rspValid = 1'b1;
            s_nxt = idlePins(s_nxt, p0Latch, p2Latch);
            s_nxt.st = ST_IDLE;
         end
      endcase

      // power modes; only the asynchronous reset pin leaves power-down, while idle is also left on wake
      if (s_r.st == ST_IDLE && !s_r.idleMode && !s_r.powerDown)
      begin
         if (powerDownReq)
         begin
            s_nxt.powerDown = 1'b1;
         end
         else if (idleReq)
         begin
            s_nxt.idleMode = 1'b1;
         end
      end
      // wake beats a same-cycle idle request, so no wake event is lost
      if (wakeIrq)
      begin
         s_nxt.idleMode = 1'b0;
      end

      // pin function muxing for the extra address lines and strobes
      s_nxt.p1Out = p1Latch;
      if (sizeSel[`XMB_SIZE_256K_BIT])
      begin
         s_nxt.p1Out[`XMB_P1_A17_BIT] = s_nxt.addr[`XMB_ADDR_A17];
      end
      s_nxt.p3Out = p3Latch;
      // strobe only pulls the latch level low, so software keeps the idle level
      s_nxt.p3Out[`XMB_P3_WR_BIT] = p3Latch[`XMB_P3_WR_BIT] & ~s_nxt.wrAct;
      if (sizeSel != `XMB_SIZE_64K)
      begin
         s_nxt.p3Out[`XMB_P3_A16_BIT] = s_nxt.addr[`XMB_ADDR_A16];
      end
      else if (rdOnPin)
      begin
         s_nxt.p3Out[`XMB_P3_A16_BIT] = p3Latch[`XMB_P3_A16_BIT] & ~s_nxt.rdAct;
      end
      s_nxt.psenN = ~s_nxt.psenAct;
      // ready is registered: it drops right after a take that starts a bus cycle, so requests never overlap
      s_nxt.reqReady = (s_nxt.st == ST_IDLE) && !s_nxt.idleMode && !s_nxt.powerDown &&
                       !coreReset;
   end

   // =====================================================================
   // state register; reset pin clears pins and power modes at once
   always_ff @(posedge clk_sys or negedge pinRst_n)
   begin
      if (!pinRst_n)
      begin
         // strap and core reset live in the qualifier; only bus, pins and power modes clear here
         s_r <= '{
            st: ST_IDLE,
            cnt: `XMB_CNT_ZERO,
            addr: `XMB_ADDR_ZERO,
            wdata: `XMB_BYTE_ZERO,
            write: 1'b0,
            code: 1'b0,
            useRd: 1'b0,
            psenAct: 1'b0,
            rdAct: 1'b0,
            wrAct: 1'b0,
            ale: 1'b0,
            p0Out: `XMB_BYTE_ZERO,
            p0Oe: `XMB_BYTE_ZERO,
            p1Out: `XMB_PORT_RESET,
            p2Out: `XMB_PORT_RESET,
            p3Out: `XMB_PORT_RESET,
            psenN: 1'b1,
            rspValid: 1'b0,
            rspInternal: 1'b0,
            rspData: `XMB_BYTE_ZERO,
            reqReady: 1'b0,
            idleMode: 1'b0,
            powerDown: 1'b0
         };
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   // =====================================================================
   // outputs straight from the state register
   assign reqReady = s_r.reqReady;
   assign rspValid = s_r.rspValid;
   assign rspInternal = s_r.rspInternal;
   assign rspData = s_r.rspData;
   assign idleMode = s_r.idleMode;
   assign powerDownMode = s_r.powerDown;
   assign muxed_low_addr_data_out = s_r.p0Out;
   assign muxed_low_addr_data_oe = s_r.p0Oe;
   assign p1Out = s_r.p1Out;
   assign upper_address_lines = s_r.p2Out;
   assign p3Out = s_r.p3Out;
   assign addrLatchStrobe = s_r.ale;
   assign program_store_strobe_n = s_r.psenN;

endmodule

//--- common/xmb_defs.svh
// constants for the external memory bus and reset pin block
`ifndef XMB_DEFS_SVH
`define XMB_DEFS_SVH

// =====================================================================
// first configuration byte layout
`define XMB_CFG_RDMAP_LO 1
`define XMB_CFG_RDMAP_HI 2
`define XMB_CFG_SIZE_LSB 5
`define XMB_CFG_SIZE_MSB 6

// external memory size field encodings
`define XMB_SIZE_64K 2'h0
`define XMB_SIZE_128K 2'h1

// read-map field encodings
`define XMB_RDMAP_ALL 2'h0
`define XMB_RDMAP_UPPER 2'h1
`define XMB_RDMAP_LOWER 2'h2
`define XMB_RDMAP_CODE 2'h3

// =====================================================================
// pin and address bit positions
`define XMB_SIZE_256K_BIT 1
`define XMB_P1_A17_BIT 7
`define XMB_P3_WR_BIT 6
`define XMB_P3_A16_BIT 7
`define XMB_ADDR_A17 17
`define XMB_ADDR_A16 16
`define XMB_ADDR_HI_MSB 15
`define XMB_ADDR_HI_LSB 8
`define XMB_ADDR_LO_MSB 7
`define XMB_ADDR_LO_LSB 0

// =====================================================================
// address map
`define XMB_ONCHIP_CODE_TOP 18'h04000
`define XMB_UPPER_64K_BASE 18'h10000

// =====================================================================
// reset values and timing
`define XMB_PORT_RESET 8'hff
`define XMB_BYTE_ZERO 8'h00
`define XMB_BYTE_ONES 8'hff
`define XMB_ADDR_ZERO 18'h00000
`define XMB_RST_HOLD_CYCLES 7'h40
`define XMB_RST_CNT_ZERO 7'h00
`define XMB_RST_CNT_ONE 7'h01
`define XMB_STROBE_CYCLES 2'h2
`define XMB_CNT_ZERO 2'h0
`define XMB_CNT_ONE 2'h1

`endif

//--- common/xmb_pkg.sv
// types for the external memory bus and reset pin block
package xmb_pkg;

   // =====================================================================
   // bus cycle phases
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ALE,
      ST_AHOLD,
      ST_STROBE,
      ST_END
   } xmb_phase_t;

   // =====================================================================
   // bus engine state
   typedef struct packed {
      xmb_phase_t st;
      logic [1:0] cnt;
      logic [17:0] addr;
      logic [7:0] wdata;
      logic write;
      logic code;
      logic useRd;
      logic psenAct;
      logic rdAct;
      logic wrAct;
      logic ale;
      logic [7:0] p0Out;
      logic [7:0] p0Oe;
      logic [7:0] p1Out;
      logic [7:0] p2Out;
      logic [7:0] p3Out;
      logic psenN;
      logic rspValid;
      logic rspInternal;
      logic [7:0] rspData;
      logic reqReady;
      logic idleMode;
      logic powerDown;
   } xmb_bus_t;

   // =====================================================================
   // reset qualifier state
   typedef struct packed {
      logic [6:0] holdCnt;
      logic coreReset;
      logic extAccess;
   } xmb_rst_t;

endpackage

//--- design/xmb_rst_qual.sv
// reset pin qualifier and external-access strap latch
`include "xmb_defs.svh"

module xmb_rst_qual
   import xmb_pkg::*;
(
   // clock and power-on reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // pins
   input wire logic rstPin,
   input wire logic extAccessPin,
   // results
   output logic coreReset,
   output logic extAccessLatched
);

   xmb_rst_t s_r;
   xmb_rst_t s_nxt;

   // =====================================================================
   // hold counter and strap capture
   always_comb
   begin
      s_nxt = s_r;
      if (rstPin)
      begin
         // short glitches on the pin never reach the core
         if (s_r.holdCnt != `XMB_RST_HOLD_CYCLES)
         begin
            s_nxt.holdCnt = s_r.holdCnt + `XMB_RST_CNT_ONE;
         end
         if (s_r.holdCnt == `XMB_RST_HOLD_CYCLES - `XMB_RST_CNT_ONE)
         begin
            s_nxt.coreReset = 1'b1;
         end
         // strap follows the pin only while reset is applied
         s_nxt.extAccess = extAccessPin;
      end
      else
      begin
         s_nxt.holdCnt = `XMB_RST_CNT_ZERO;
         s_nxt.coreReset = 1'b0;
      end
   end

   // =====================================================================
   // state register; power-on puts the core in reset, off-chip fetch
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_r <= '{holdCnt: `XMB_RST_CNT_ZERO, coreReset: 1'b1, extAccess: 1'b0};
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   assign coreReset = s_r.coreReset;
   assign extAccessLatched = s_r.extAccess;

endmodule

//--- tb/xmb_ext_bus_chk.sv
// assertion checker for the external memory bus and reset pin block
`include "xmb_defs.svh"

// =====================================================================
// checker
module xmb_ext_bus_chk
   import xmb_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // inputs watched
   input wire logic rstPin,
   input wire logic [7:0] first_configuration_byte,
   input wire logic [7:0] p0Latch,
   input wire logic reqValid,
   input wire logic reqWrite,
   input wire logic reqCode,
   input wire logic [17:0] reqAddr,
   input wire logic [7:0] reqWdata,
   // outputs watched
   input wire logic reqReady,
   input wire logic rspValid,
   input wire logic rspInternal,
   input wire logic coreReset,
   input wire logic extAccessLatched,
   input wire logic idleMode,
   input wire logic [7:0] muxed_low_addr_data_out,
   input wire logic [7:0] muxed_low_addr_data_oe,
   input wire logic [7:0] p1Out,
   input wire logic [7:0] upper_address_lines,
   input wire logic [7:0] p3Out,
   input wire logic addrLatchStrobe,
   input wire logic program_store_strobe_n
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [6:0] hiCnt_r;
   logic take;
   logic rdPin;

   // consecutive edges with reset pin high, saturating so it never wraps
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         hiCnt_r <= 7'h00;
      else
         hiCnt_r <= !rstPin ? 7'h00 : hiCnt_r + {6'h00, hiCnt_r != 7'h7f};
   end

   // request taken, and read pin in use
   assign take = reqValid && reqReady;
   assign rdPin = first_configuration_byte[6:5] == 2'h0 && first_configuration_byte[2:1] == 2'h3;

   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   // =====================================================================
   // assertions
   AST_FLOAT: assert property (
      reqReady && $past(reqReady) && $stable(p0Latch) |-> muxed_low_addr_data_oe == ~p0Latch)
      else $error("port 0 not floating");
   AST_ADDR: assert property (
      addrLatchStrobe |-> muxed_low_addr_data_out == $past(reqAddr[7:0])
      && muxed_low_addr_data_oe == 8'hff && upper_address_lines == $past(reqAddr[15:8]))
      else $error("address not valid at latch strobe");
   AST_ANSWER: assert property (
      addrLatchStrobe |=> !addrLatchStrobe [*4] ##1 rspValid && !rspInternal)
      else $error("bus cycle length wrong");
   AST_EXTCODE: assert property (
      take && reqCode && !extAccessLatched |=> addrLatchStrobe ##2 !program_store_strobe_n)
      else $error("fetch not off-chip");
   AST_ONCHIP: assert property (
      take && reqCode && extAccessLatched |=> rspInternal == ($past(reqAddr) < `XMB_ONCHIP_CODE_TOP))
      else $error("fetch routed wrong");
   AST_RDPIN: assert property (
      addrLatchStrobe && !$past(reqCode) && !$past(reqWrite) && rdPin
      |-> ##2 program_store_strobe_n && !p3Out[7])
      else $error("read strobe wrong");
   AST_HIADDR: assert property (
      addrLatchStrobe && first_configuration_byte[6]
      |-> p1Out[7] == $past(reqAddr[17]) && p3Out[7] == $past(reqAddr[16]))
      else $error("high address bits wrong");
   AST_WRITE: assert property (
      addrLatchStrobe && $past(reqWrite) |-> ##2 !p3Out[6] && program_store_strobe_n
      && muxed_low_addr_data_out == $past(reqWdata, 3))
      else $error("write strobe wrong");
   AST_RSTPIN: assert property (
      rstPin |-> upper_address_lines == 8'hff && muxed_low_addr_data_oe == 8'h00 && !idleMode)
      else $error("pins not forced by reset pin");
   AST_QUAL: assert property (
      $rose(coreReset) |-> hiCnt_r == 7'h40)
      else $error("core reset at wrong count");
   AST_STRAP: assert property (
      !rstPin |=> $stable(extAccessLatched))
      else $error("strap changed outside reset");

   // main scenarios reached
   COV_WRITE: cover property (take && reqWrite);
   COV_ONCHIP: cover property (take && reqCode && extAccessLatched);
   COV_QUAL: cover property ($rose(coreReset));
endmodule

bind xmb_ext_bus xmb_ext_bus_chk u_chk (.clk_sys(clk_sys), .rst_n(rst_n), .rstPin(rstPin),
   .first_configuration_byte(first_configuration_byte), .p0Latch(p0Latch),
   .reqValid(reqValid), .reqWrite(reqWrite), .reqCode(reqCode), .reqAddr(reqAddr),
   .reqWdata(reqWdata), .reqReady(reqReady), .rspValid(rspValid),
   .rspInternal(rspInternal), .coreReset(coreReset), .extAccessLatched(extAccessLatched),
   .idleMode(idleMode), .muxed_low_addr_data_out(muxed_low_addr_data_out),
   .muxed_low_addr_data_oe(muxed_low_addr_data_oe), .p1Out(p1Out),
   .upper_address_lines(upper_address_lines), .p3Out(p3Out),
   .addrLatchStrobe(addrLatchStrobe), .program_store_strobe_n(program_store_strobe_n));

//--- tb/xmb_ext_mem.sv
// external memory with address latch on the far side of the bus
module xmb_ext_mem
   import xmb_pkg::*;
(
   // clock
   input wire logic clk_sys,
   // bus pins
   input wire logic addrLatchStrobe,
   input wire logic program_store_strobe_n,
   input wire logic [7:0] p0Pin,
   input wire logic [7:0] p3Out,
   input wire logic [7:0] cfgByte,
   // read data drive onto port 0
   output logic [7:0] memDrive,
   output logic memOe
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [0:255];
   logic [7:0] lowAddr_r;

   // seeded contents so reads check before any write
   initial
   begin
      for (int i = 0; i < 256; i++)
         mem[i] = 8'(i) ^ 8'h5a;
   end

   // low byte latched on the strobe, held while data owns the lines
   always @(posedge clk_sys)
   begin
      if (addrLatchStrobe)
         lowAddr_r <= p0Pin;
      if (!p3Out[6])
         mem[lowAddr_r] <= p0Pin;
   end

   // read pin exists only in the smallest space; bit 7 is address otherwise
   assign memOe = !program_store_strobe_n
      || (cfgByte[6:5] == 2'h0 && cfgByte[2:1] == 2'h3 && !p3Out[7]);
   assign memDrive = mem[lowAddr_r];
endmodule

//--- tb/tb.sv
// self-checking bench for the external memory bus and reset pin block
module tb
   import xmb_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic rstPin = 1'b0;
   logic strap = 1'b0;
   logic idleReq = 1'b0;
   logic pdReq = 1'b0;
   logic wake = 1'b0;
   logic pdMode;
   logic reqValid = 1'b0;
   logic reqWrite = 1'b0;
   logic reqCode = 1'b0;
   logic [7:0] cfg = 8'h00;
   logic [7:0] p0Latch = 8'hff;
   logic [7:0] reqWdata = 8'h00;
   logic [17:0] reqAddr = 18'h00000;
   logic reqReady, rspValid, rspInternal, coreReset, extAccess, idleMode, ale, psenN, memOe;
   logic [7:0] rspData, p0Out, p0Oe, p1Out, p2Out, p3Out, memDrive, p0Pin;
   logic [7:0] p0Last = 8'h00;
   int n_mismatch = 0;
   int check_count = 0;
   int cyc = 0;

   // released lines show the memory drive when it is on, else the inverse of their last level
   assign p0Pin = (p0Oe & p0Out) | (~p0Oe & (memOe ? memDrive : ~p0Last));
   always #10 clk_sys = ~clk_sys;

   xmb_ext_bus DUT (.clk_sys(clk_sys), .rst_n(rst_n), .rstPin(rstPin),
      .external_access_select(strap), .first_configuration_byte(cfg), .p0Latch(p0Latch),
      .p1Latch(8'hff), .p2Latch(8'h3c), .p3Latch(8'hff), .idleReq(idleReq),
      .powerDownReq(pdReq), .wakeIrq(wake), .reqValid(reqValid), .reqWrite(reqWrite),
      .reqCode(reqCode), .reqAddr(reqAddr), .reqWdata(reqWdata), .reqReady(reqReady),
      .rspValid(rspValid), .rspInternal(rspInternal), .rspData(rspData),
      .coreReset(coreReset), .extAccessLatched(extAccess), .idleMode(idleMode),
      .powerDownMode(pdMode), .muxed_low_addr_data_in(p0Pin), .muxed_low_addr_data_out(p0Out),
      .muxed_low_addr_data_oe(p0Oe), .p1Out(p1Out), .upper_address_lines(p2Out),
      .p3Out(p3Out), .addrLatchStrobe(ale), .program_store_strobe_n(psenN));

   xmb_ext_mem mem0 (.clk_sys(clk_sys), .addrLatchStrobe(ale), .program_store_strobe_n(psenN),
      .p0Pin(p0Pin), .p3Out(p3Out), .cfgByte(cfg), .memDrive(memDrive), .memOe(memOe));

   // =====================================================================
   // helpers
   // last pin level and the hang guard
   always @(posedge clk_sys)
   begin
      p0Last <= p0Pin;
      cyc++;
      if (cyc == 3000)
      begin
         n_mismatch++;
         finish_test();
      end
   end

   task check(input logic [17:0] seen, input logic [17:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // request held until the edge that takes it, answer waited for under a bound
   task access(input logic wr, input logic code, input logic [17:0] addr, input logic [7:0] wd);
      @(posedge clk_sys);
      reqValid <= 1'b1;
      reqWrite <= wr;
      reqCode <= code;
      reqAddr <= addr;
      reqWdata <= wd;
      for (int n = 0; n < 40; n++)
      begin
         #1;
         if (reqReady === 1'b1)
            break;
         @(posedge clk_sys);
      end
      @(posedge clk_sys);
      reqValid <= 1'b0;
      for (int n = 0; n < 20; n++)
      begin
         #1;
         if (rspValid === 1'b1)
            break;
         @(posedge clk_sys);
      end
      check(rspValid, 1'b1);
   endtask

   // =====================================================================
   // scenarios
   task t_reset();
      repeat (11) @(posedge clk_sys);
      check(p2Out, 8'hff);
      check(p0Oe, 8'h00);
      @(posedge clk_sys);
      rst_n <= 1'b1;
      p0Latch <= 8'h0f;
      repeat (4) @(posedge clk_sys);
      #1;
      check(p0Oe, 8'hf0);
   endtask

   // every read map and size codes 0 to 2, then a write read back at the top space
   task t_bus();
      logic [7:0] cfgs [6];
      cfgs = '{8'h00, 8'h02, 8'h04, 8'h06, 8'h20, 8'h40};
      access(1'b0, 1'b1, 18'h00123, 8'h00);
      check(rspInternal, 1'b0);
      check(rspData, 8'h23 ^ 8'h5a);
      for (int i = 0; i < 6; i++)
      begin
         @(posedge clk_sys);
         cfg <= cfgs[i];
         access(1'b0, 1'b0, 18'h10050 + 18'(i), 8'h00);
         check(rspData, (8'h50 + 8'(i)) ^ 8'h5a);
      end
      access(1'b1, 1'b0, 18'h30077, 8'h3c);
      access(1'b0, 1'b0, 18'h30077, 8'h00);
      check(rspData, 8'h3c);
   endtask

   // pulse too short to reset the core still forces the pins
   task t_short();
      @(posedge clk_sys);
      rstPin <= 1'b1;
      repeat (20) @(posedge clk_sys);
      #1;
      check(p2Out, 8'hff);
      check(coreReset, 1'b0);
      @(posedge clk_sys);
      rstPin <= 1'b0;
   endtask

   // idle ended by the reset pin, strap held after it
   task t_strap();
      @(posedge clk_sys);
      idleReq <= 1'b1;
      @(posedge clk_sys);
      idleReq <= 1'b0;
      repeat (2) @(posedge clk_sys);
      #1;
      check(idleMode, 1'b1);
      @(posedge clk_sys);
      rstPin <= 1'b1;
      strap <= 1'b1;
      #1;
      check(idleMode, 1'b0);
      repeat (70) @(posedge clk_sys);
      rstPin <= 1'b0;
      #1;
      check(coreReset, 1'b1);
      @(posedge clk_sys);
      strap <= 1'b0;
      access(1'b0, 1'b1, 18'h00100, 8'h00);
      check(rspInternal, 1'b1);
      check(extAccess, 1'b1);
      access(1'b0, 1'b1, 18'h04000, 8'h00);
      check(rspInternal, 1'b0);
   endtask

   // power-down left only by the reset pin; wake ends idle alone
   task t_power();
      @(posedge clk_sys);
      pdReq <= 1'b1;
      @(posedge clk_sys);
      pdReq <= 1'b0;
      wake <= 1'b1;
      @(posedge clk_sys);
      wake <= 1'b0;
      #1;
      check(pdMode, 1'b1);
      check(reqReady, 1'b0);
      @(posedge clk_sys);
      rstPin <= 1'b1;
      #1;
      check(pdMode, 1'b0);
      @(posedge clk_sys);
      rstPin <= 1'b0;
      @(posedge clk_sys);
      idleReq <= 1'b1;
      @(posedge clk_sys);
      idleReq <= 1'b0;
      wake <= 1'b1;
      #1;
      check(idleMode, 1'b1);
      @(posedge clk_sys);
      wake <= 1'b0;
      #1;
      check(idleMode, 1'b0);
   endtask

   task finish_test();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // main sequence
   initial
   begin
      t_reset();
      t_bus();
      t_short();
      t_strap();
      t_power();
      finish_test();
   end
endmodule
